//--- design/sfp_framer.sv
// serial-to-network packet framer for one serial port, APB registers
//
// Notes on behaviour
// - port selector picks one port; zero selects all; defaults to port one
// - line rate register, defaults to 9600 bps
// - character size, parity and stop bits; default eight, none, one
// - rx queue moves to buffer at trigger count, default one
// - idle gap of configured milliseconds ends the transfer; default zero
// - flush when buffer fill reaches level 1..1460, default 1460
// - terminator byte match flushes at once; zero disables, default; only the byte that completes the trigger count is compared
// - four modes: shared, single, half, gateway; shared default
// - single mode: reply timeout from last request byte, default 200 ms
// - master ack timeout returns ack byte; zero disables, default
// - store option writes nonvolatile copy only, no immediate effect; nv_q keeps only port, mode, trigger, line bits 21:0, cleared by reset
// - apply option makes settings active at once
// - shared mode sends serial data to every client
// - single mode sends only to requester, nothing unrequested
// - half mode: shared with one client, single otherwise; last client
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ns
module sfp_framer
    import sfp_pkg::*;
#(
    parameter int MS_CYCLES = SFP_MS_CYC,
    parameter int NCLI = 4,
    parameter int NPORT = 4
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial receive byte from the port queue
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    // request byte sent to the serial device, with requesting client
    input wire logic req_sent,
    input wire logic req_last,
    input wire logic [NCLI-1:0] req_client,
    input wire logic [NCLI-1:0] cli_connected,
    // packet out to network
    output logic [7:0] pkt_data,
    output logic pkt_valid,
    output logic pkt_end,
    output logic [NCLI-1:0] pkt_dest,
    output logic ack_pulse,
    output logic sto_err,
    // active line settings
    output logic [31:0] line_cfg,
    output logic [NPORT-1:0] port_apply,
    output logic [1:0] op_mode,
    // interrupt
    output logic irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    if (NCLI < 1 || NPORT < 1 || NPORT > 15 || MS_CYCLES < 1)
        $error("sfp_framer: bad parameter");

    // staged (written) and active settings
    logic [3:0] port_q;
    logic [1:0] smode_q, amode_q;
    logic [3:0] strig_q, atrig_q;
    logic [31:0] sline_q, aline_q;
    logic [15:0] sidle_q, aidle_q, ssto_q, asto_q, smat_q, amat_q;
    logic [10:0] sfill_q, afill_q;
    logic [7:0] sterm_q, aterm_q;
    logic [31:0] nv_q;
    logic [SFP_IRQ_W-1:0] stat_q, mask_q, ev;
    logic wr, rd, cmd_wr;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign cmd_wr = wr && paddr == SFP_OFF_CMD;
    assign pready = 1'b1;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port_q <= SFP_RST_PORT;
            smode_q <= SFP_SHARED;
            strig_q <= SFP_RST_TRIG;
            sline_q <= SFP_RST_LINE;
            sidle_q <= SFP_RST_IDLE;
            sfill_q <= SFP_RST_FILL;
            sterm_q <= SFP_RST_TERM;
            ssto_q <= SFP_RST_STO;
            smat_q <= SFP_RST_MAT;
            mask_q <= '0;
        end
        else if (wr)
        begin
            case (paddr)
                SFP_OFF_CTRL:
                begin
                    port_q <= pwdata[SFP_CTRL_PORT_LSB +: 4];
                    smode_q <= pwdata[SFP_CTRL_MODE_LSB +: 2];
                    strig_q <= (pwdata[SFP_CTRL_TRIG_LSB +: 4] == 4'h0) ? 4'h1
                        : pwdata[SFP_CTRL_TRIG_LSB +: 4];
                end
                SFP_OFF_LINE: sline_q <= {7'h00, pwdata[24:0]};
                SFP_OFF_IDLE: sidle_q <= pwdata[15:0];
                SFP_OFF_FILL: sfill_q <= (pwdata[10:0] == 11'h000) ? 11'h001
                    : ((pwdata[10:0] > SFP_MAX_FILL) ? SFP_MAX_FILL : pwdata[10:0]);
                SFP_OFF_TERM: sterm_q <= pwdata[7:0];
                SFP_OFF_STO: ssto_q <= pwdata[15:0];
                SFP_OFF_MAT: smat_q <= pwdata[15:0];
                SFP_OFF_MASK: mask_q <= pwdata[SFP_IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // apply and store commands
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            amode_q <= SFP_SHARED;
            atrig_q <= SFP_RST_TRIG;
            aline_q <= SFP_RST_LINE;
            aidle_q <= SFP_RST_IDLE;
            afill_q <= SFP_RST_FILL;
            aterm_q <= SFP_RST_TERM;
            asto_q <= SFP_RST_STO;
            amat_q <= SFP_RST_MAT;
            port_apply <= '0;
            nv_q <= '0;
        end
        else
        begin
            port_apply <= '0;
            if (cmd_wr && pwdata[SFP_CMD_APPLY])
            begin
                amode_q <= smode_q;
                atrig_q <= strig_q;
                aline_q <= sline_q;
                aidle_q <= sidle_q;
                afill_q <= sfill_q;
                aterm_q <= sterm_q;
                asto_q <= ssto_q;
                amat_q <= smat_q;
                for (int i = 0; i < NPORT; i++)
                    port_apply[i] <= (port_q == SFP_ALL_PORTS)
                        || (port_q == 4'(i + 1));
            end
            if (cmd_wr && pwdata[SFP_CMD_STORE])
                nv_q <= {port_q, smode_q, strig_q, sline_q[21:0]};
        end
    end
    assign line_cfg = aline_q;
    assign op_mode = amode_q;

    // millisecond tick
    logic [$clog2(MS_CYCLES+1)-1:0] div_q;
    logic ms_tick;
    assign ms_tick = div_q == '0;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_q <= '0;
        else
            div_q <= ms_tick ? ($bits(div_q))'(MS_CYCLES - 1) : div_q - 1'b1;
    end

    // rx queue and packet buffer counting
    logic [3:0] q_cnt_q;
    logic [10:0] fill_q;
    logic [15:0] idle_ms_q;
    logic move, flush_fill, flush_term, flush_idle, flush;
    assign move = rx_valid && (q_cnt_q + 4'h1 >= atrig_q);
    assign flush_fill = move && (fill_q + 11'h001 >= afill_q);
    assign flush_term = move && aterm_q != 8'h00 && rx_data == aterm_q;
    assign flush_idle = aidle_q != 16'h0000 && fill_q != 11'h000
        && ms_tick && idle_ms_q >= aidle_q;
    assign flush = flush_fill || flush_term || flush_idle;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q_cnt_q <= '0;
            fill_q <= '0;
            idle_ms_q <= '0;
        end
        else
        begin
            q_cnt_q <= move ? 4'h0 : (rx_valid ? q_cnt_q + 4'h1 : q_cnt_q);
            if (flush)
                fill_q <= '0;
            else if (move)
                fill_q <= fill_q + 11'h001;
            if (rx_valid || flush)
                idle_ms_q <= '0;
            else if (ms_tick)
                idle_ms_q <= idle_ms_q + 16'h0001;
        end
    end

    // destination selection by mode
    logic [NCLI-1:0] last_cli_q, requester_q;
    logic [$clog2(NCLI+1)-1:0] ncon;
    always_comb
    begin
        ncon = '0;
        for (int i = 0; i < NCLI; i++)
            ncon = ncon + ($bits(ncon))'(cli_connected[i]);
    end
    logic [NCLI-1:0] dest;
    always_comb
    begin
        case (sfp_mode_t'(amode_q))
            SFP_SHARED: dest = cli_connected;
            SFP_SINGLE: dest = requester_q & cli_connected;
            SFP_HALF: dest = (ncon <= 1) ? cli_connected
                : ((requester_q != '0) ? requester_q : last_cli_q) & cli_connected;
            default: dest = requester_q;
        endcase
    end

    // slave timeout / master ack timer
    sfp_st_t st_q;
    logic [15:0] wait_ms_q;
    logic sto_hit, mat_hit;
    assign sto_hit = st_q == SFP_WAIT && amode_q == SFP_SINGLE && ms_tick
        && wait_ms_q >= asto_q && !rx_valid;
    assign mat_hit = st_q == SFP_WAIT && amode_q != SFP_SINGLE && amat_q != 16'h0000
        && ms_tick && wait_ms_q >= amat_q && !rx_valid;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q <= SFP_IDLE;
            wait_ms_q <= '0;
            requester_q <= '0;
            last_cli_q <= '0;
        end
        else
        begin
            if (req_sent && req_client != '0)
            begin
                requester_q <= req_client;
                last_cli_q <= req_client;
            end
            case (st_q)
                SFP_IDLE:
                    if (req_sent && req_last)
                    begin
                        st_q <= SFP_WAIT;
                        wait_ms_q <= '0;
                    end
                SFP_WAIT:
                    if (rx_valid)
                        st_q <= SFP_REPLY;
                    else if (sto_hit || mat_hit)
                    begin
                        st_q <= SFP_IDLE;
                        requester_q <= '0;
                    end
                    else if (ms_tick)
                        wait_ms_q <= wait_ms_q + 16'h0001;
                SFP_REPLY:
                    if (flush)
                    begin
                        st_q <= SFP_IDLE;
                        requester_q <= '0;
                    end
                default: st_q <= SFP_IDLE;
            endcase
        end
    end

    // packet output
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pkt_data <= '0;
            pkt_valid <= 1'b0;
            pkt_end <= 1'b0;
            pkt_dest <= '0;
            ack_pulse <= 1'b0;
            sto_err <= 1'b0;
        end
        else
        begin
            pkt_valid <= move;
            if (move)
                pkt_data <= rx_data;
            pkt_end <= flush;
            pkt_dest <= dest;
            ack_pulse <= mat_hit;
            sto_err <= sto_hit;
        end
    end

    // interrupt status, write one to clear, set wins
    assign ev = {mat_hit, sto_hit, flush};
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stat_q <= '0;
        else
            stat_q <= ev | (stat_q & ~((wr && paddr == SFP_OFF_IRQ)
                ? pwdata[SFP_IRQ_W-1:0] : '0));
    end
    assign irq = |(stat_q & ~mask_q);

    // read mux
    always_comb
    begin
        prdata = '0;
        pslverr = 1'b0;
        case (paddr)
            SFP_OFF_CTRL: prdata = {22'h0, strig_q, smode_q, port_q};
            SFP_OFF_LINE: prdata = sline_q;
            SFP_OFF_IDLE: prdata = {16'h0, sidle_q};
            SFP_OFF_FILL: prdata = {21'h0, sfill_q};
            SFP_OFF_TERM: prdata = {24'h0, sterm_q};
            SFP_OFF_STO: prdata = {16'h0, ssto_q};
            SFP_OFF_MAT: prdata = {16'h0, smat_q};
            SFP_OFF_CMD: prdata = '0;
            SFP_OFF_STAT: prdata = {3'h0, fill_q, 14'h0, st_q, amode_q};
            SFP_OFF_IRQ: prdata = {29'h0, stat_q};
            SFP_OFF_MASK: prdata = {29'h0, mask_q};
            SFP_OFF_NV: prdata = nv_q;
            default: pslverr = psel && penable;
        endcase
        if (!rd)
            prdata = '0;
    end

    // checks
    a_fill_flush: assert property (move && fill_q + 11'h001 >= afill_q
        |=> pkt_end && fill_q == 11'h000) else $error("fill level did not flush");
    a_term_flush: assert property (move && aterm_q != 8'h00 && rx_data == aterm_q
        |=> pkt_end) else $error("terminator did not flush");
    a_idle_flush: assert property (flush_idle |=> pkt_end && fill_q == 11'h000)
        else $error("idle gap did not flush");
    a_term_off: assert property (aterm_q == 8'h00 && !flush_fill && !flush_idle
        |=> !pkt_end) else $error("spurious flush");
    a_sto_err: assert property (sto_hit |=> sto_err && st_q == SFP_IDLE)
        else $error("slave timeout not reported");
    a_mat_off: assert property (amat_q == 16'h0000 |=> !ack_pulse)
        else $error("ack sent while disabled");
    a_single_dest: assert property (amode_q == SFP_SINGLE && requester_q == '0
        |=> pkt_dest == '0) else $error("unrequested data forwarded");
    a_shared_dest: assert property (amode_q == SFP_SHARED
        |=> pkt_dest == $past(cli_connected)) else $error("shared mode did not reach all");
    a_apply_now: assert property (cmd_wr && pwdata[SFP_CMD_APPLY]
        |=> aline_q == $past(sline_q)) else $error("apply did not take effect");
    a_store_only: assert property (cmd_wr && !pwdata[SFP_CMD_APPLY]
        |=> $stable(aline_q)) else $error("store changed active settings");
    a_all_ports: assert property (cmd_wr && pwdata[SFP_CMD_APPLY]
        && port_q == SFP_ALL_PORTS |=> &port_apply) else $error("all ports not applied");
    c_fill: cover property (flush_fill);
    c_term: cover property (flush_term);
    c_sto: cover property (sto_hit);
    c_ack: cover property (mat_hit);
endmodule : sfp_framer

//--- inc/sfp_pkg.sv
// package of constants for the serial packet framer
package sfp_pkg;
    // register byte offsets
    localparam logic [7:0] SFP_OFF_CTRL = 8'h00;
    localparam logic [7:0] SFP_OFF_LINE = 8'h04;
    localparam logic [7:0] SFP_OFF_IDLE = 8'h08;
    localparam logic [7:0] SFP_OFF_FILL = 8'h0C;
    localparam logic [7:0] SFP_OFF_TERM = 8'h10;
    localparam logic [7:0] SFP_OFF_STO = 8'h14;
    localparam logic [7:0] SFP_OFF_MAT = 8'h18;
    localparam logic [7:0] SFP_OFF_CMD = 8'h1C;
    localparam logic [7:0] SFP_OFF_STAT = 8'h20;
    localparam logic [7:0] SFP_OFF_IRQ = 8'h24;
    localparam logic [7:0] SFP_OFF_MASK = 8'h28;
    localparam logic [7:0] SFP_OFF_NV = 8'h2C;
    // ctrl fields: [3:0] port selector, [5:4] mode, [9:6] rx trigger
    localparam int SFP_CTRL_PORT_LSB = 0;
    localparam int SFP_CTRL_MODE_LSB = 4;
    localparam int SFP_CTRL_TRIG_LSB = 6;
    // line fields: [19:0] baud, [21:20] size code, [23:22] parity, [24] stop
    localparam int SFP_LINE_PAR_LSB = 22;
    localparam int SFP_LINE_STOP_BIT = 24;
    // command bits
    localparam int SFP_CMD_APPLY = 0;
    localparam int SFP_CMD_STORE = 1;
    // interrupt bits
    localparam int SFP_IRQ_FLUSH = 0;
    localparam int SFP_IRQ_STO = 1;
    localparam int SFP_IRQ_ACK = 2;
    localparam int SFP_IRQ_W = 3;
    // reset values
    localparam logic [3:0] SFP_RST_PORT = 4'h1;
    localparam logic [31:0] SFP_RST_LINE = 32'h0030_2580;
    localparam logic [3:0] SFP_RST_TRIG = 4'h1;
    localparam logic [15:0] SFP_RST_IDLE = 16'h0000;
    localparam logic [10:0] SFP_RST_FILL = 11'h5B4;
    localparam logic [10:0] SFP_MAX_FILL = 11'h5B4;
    localparam logic [7:0] SFP_RST_TERM = 8'h00;
    localparam logic [15:0] SFP_RST_STO = 16'h00C8;
    localparam logic [15:0] SFP_RST_MAT = 16'h0000;
    localparam logic [3:0] SFP_ALL_PORTS = 4'h0;
    // timebase
    localparam int SFP_CLK_MHZ = 100;
    localparam int SFP_MS_US = 1000;
    localparam int SFP_MS_CYC = SFP_CLK_MHZ * SFP_MS_US;
    typedef enum logic [1:0]
    {
        SFP_SHARED = 2'b00,
        SFP_SINGLE = 2'b01,
        SFP_HALF = 2'b10,
        SFP_GATEWAY = 2'b11
    } sfp_mode_t;
    typedef enum logic [1:0]
    {
        SFP_IDLE = 2'b00,
        SFP_WAIT = 2'b01,
        SFP_REPLY = 2'b11
    } sfp_st_t;
endpackage : sfp_pkg

//--- tb/sfp_serial_dev.sv
// serial device model feeding the port receive queue
`timescale 1ns/1ns
module sfp_serial_dev
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench commands
    input wire logic tx_go,
    input wire logic [7:0] tx_b,
    input wire logic reply_en,
    input wire logic [7:0] reply_gap,
    // request seen by the device
    input wire logic req_sent,
    input wire logic req_last,
    // received byte stream
    output logic rx_valid,
    output logic [7:0] rx_data
);
    logic [7:0] gap_q;

    // one byte per command, or a reply some cycles after a request
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
            gap_q <= 8'h00;
        end
        else
        begin
            rx_valid <= 1'b0;
            rx_data <= ~rx_data;
            if (req_sent && req_last && reply_en)
                gap_q <= reply_gap;
            else if (gap_q != 8'h00)
                gap_q <= gap_q - 8'h01;
            if (tx_go)
            begin
                rx_valid <= 1'b1;
                rx_data <= tx_b;
            end
            else if (gap_q == 8'h01)
            begin
                rx_valid <= 1'b1;
                rx_data <= 8'h5A;
            end
        end
    end
endmodule : sfp_serial_dev

//--- tb/test_serial_to_net_packetizer.sv
// self-checking bench for the serial packet framer
`timescale 1ns/1ns
module test_serial_to_net_packetizer
    import sfp_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr, rx_data, pkt_data, tx_b, reply_gap, end_data;
    logic [31:0] pwdata, prdata, line_cfg, r;
    logic rx_valid, req_sent, req_last, pkt_valid, pkt_end, ack_pulse, sto_err, irq;
    logic tx_go, reply_en;
    logic [3:0] req_client, cli_connected, pkt_dest, port_apply, end_dest, app_seen;
    logic [1:0] op_mode;
    int n_mismatch, check_count, cyc, n_val, n_end, n_sto, n_ack, d, e0;

    sfp_framer #(.MS_CYCLES(10), .NCLI(4), .NPORT(4)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
        .rx_data(rx_data), .req_sent(req_sent), .req_last(req_last), .req_client(req_client),
        .cli_connected(cli_connected), .pkt_data(pkt_data), .pkt_valid(pkt_valid),
        .pkt_end(pkt_end), .pkt_dest(pkt_dest), .ack_pulse(ack_pulse), .sto_err(sto_err),
        .line_cfg(line_cfg), .port_apply(port_apply), .op_mode(op_mode), .irq(irq));
    sfp_serial_dev dev (.pclk(pclk), .presetn(presetn), .tx_go(tx_go), .tx_b(tx_b),
        .reply_en(reply_en), .reply_gap(reply_gap), .req_sent(req_sent),
        .req_last(req_last), .rx_valid(rx_valid), .rx_data(rx_data));

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // event recorder and hang limit
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (pkt_valid === 1'b1)
            n_val <= n_val + 1;
        if (sto_err === 1'b1)
            n_sto <= n_sto + 1;
        if (ack_pulse === 1'b1)
            n_ack <= n_ack + 1;
        if (port_apply !== 4'h0)
            app_seen <= port_apply;
        if (pkt_end === 1'b1)
        begin
            n_end <= n_end + 1;
            end_data <= pkt_data;
            end_dest <= pkt_dest;
        end
        if (cyc == 20000)
        begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dt);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= dt;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk("register read", r & m, x);
    endtask : rd

    task automatic set(input logic [7:0] a, input logic [31:0] dt);
        apb(1'b1, a, dt);
        apb(1'b1, SFP_OFF_CMD, 32'h1);
        repeat (2) @(posedge pclk);
    endtask : set

    task automatic ctrl(input logic [3:0] p, input logic [1:0] m, input logic [3:0] t);
        set(SFP_OFF_CTRL, {22'h0, t, m, p});
    endtask : ctrl

    task automatic sb(input logic [7:0] b);
        @(posedge pclk);
        tx_go <= 1'b1;
        tx_b <= b;
        @(posedge pclk);
        tx_go <= 1'b0;
    endtask : sb

    task automatic rq(input logic [3:0] cl);
        @(posedge pclk);
        req_sent <= 1'b1;
        req_last <= 1'b1;
        req_client <= cl;
        @(posedge pclk);
        req_sent <= 1'b0;
        req_last <= 1'b0;
    endtask : rq

    function automatic int cnt(input int sel);
        return (sel == 0) ? n_end : ((sel == 1) ? n_sto : n_ack);
    endfunction : cnt

    task automatic wt(input int sel);
        int n0;
        n0 = cnt(sel);
        d = 0;
        while (cnt(sel) == n0 && d < 300)
        begin
            @(posedge pclk);
            d++;
        end
    endtask : wt

    task automatic t_defaults();
        chk("line_cfg", line_cfg, 32'h0030_2580);
        chk("line format", {27'h0, line_cfg[24:20]}, 32'h3);
        chk("op_mode", {30'h0, op_mode}, 32'h0);
        rd(SFP_OFF_CTRL, 32'h3FF, 32'h41);
        rd(SFP_OFF_IDLE, 32'hFFFF, 32'h0);
        rd(SFP_OFF_FILL, 32'h7FF, 32'h5B4);
        rd(SFP_OFF_TERM, 32'hFF, 32'h0);
        rd(SFP_OFF_STO, 32'hFFFF, 32'hC8);
        rd(SFP_OFF_MAT, 32'hFFFF, 32'h0);
        $display("test defaults done");
    endtask : t_defaults

    task automatic t_apply();
        apb(1'b1, SFP_OFF_LINE, 32'h0030_4B00);
        repeat (2) @(posedge pclk);
        chk("line before apply", line_cfg, 32'h0030_2580);
        apb(1'b1, SFP_OFF_CMD, 32'h1);
        repeat (2) @(posedge pclk);
        chk("line after apply", line_cfg, 32'h0030_4B00);
        chk("apply port one", {28'h0, app_seen}, 32'h1);
        for (int m = 3; m >= 0; m--)
        begin
            ctrl(4'h0, 2'(m), 4'h1);
            chk("mode", {30'h0, op_mode}, 32'(m));
        end
        chk("apply all ports", {28'h0, app_seen}, 32'hF);
        apb(1'b1, SFP_OFF_LINE, 32'h0030_E100);
        apb(1'b1, SFP_OFF_CMD, 32'h2);
        repeat (3) @(posedge pclk);
        chk("line after store", line_cfg, 32'h0030_4B00);
        rd(SFP_OFF_NV, 32'hFFFF_FFFF, 32'h0070_E100);
        $display("test apply done");
    endtask : t_apply

    task automatic t_flush();
        cli_connected <= 4'hB;
        set(SFP_OFF_TERM, 32'h0D);
        e0 = n_end;
        sb(8'h41);
        sb(8'h0D);
        wt(0);
        chk("term flush count", 32'(n_end - e0), 32'h1);
        chk("term byte", {24'h0, end_data}, 32'h0D);
        chk("shared dest", {28'h0, end_dest}, 32'hB);
        set(SFP_OFF_FILL, 32'h3);
        sb(8'h11);
        sb(8'h22);
        sb(8'h33);
        wt(0);
        chk("fill flush byte", {24'h0, end_data}, 32'h33);
        set(SFP_OFF_FILL, 32'h5B4);
        set(SFP_OFF_IDLE, 32'h2);
        sb(8'h44);
        wt(0);
        chk("idle gap", 32'(d >= 23 && d <= 33), 32'h1);
        chk("idle byte", {24'h0, end_data}, 32'h44);
        ctrl(4'h0, 2'h0, 4'h2);
        e0 = n_val;
        sb(8'h01);
        sb(8'h02);
        repeat (4) @(posedge pclk);
        chk("trigger two", 32'(n_val - e0), 32'h1);
        ctrl(4'h0, 2'h0, 4'h1);
        $display("test flush done");
    endtask : t_flush

    task automatic t_timeouts();
        ctrl(4'h0, 2'h1, 4'h1);
        set(SFP_OFF_STO, 32'h3);
        rq(4'h1);
        wt(1);
        chk("slave timeout", 32'(d >= 32 && d <= 42), 32'h1);
        rd(SFP_OFF_IRQ, 32'h2, 32'h2);
        reply_en <= 1'b1;
        e0 = n_sto;
        rq(4'h8);
        wt(0);
        repeat (20) @(posedge pclk);
        chk("requester dest", {28'h0, end_dest}, 32'h8);
        chk("reply byte", {24'h0, end_data}, 32'h5A);
        chk("no timeout on reply", 32'(n_sto - e0), 32'h0);
        reply_en <= 1'b0;
        ctrl(4'h0, 2'h0, 4'h1);
        set(SFP_OFF_MAT, 32'h2);
        rq(4'h1);
        wt(2);
        chk("master ack", 32'(d >= 22 && d <= 32), 32'h1);
        set(SFP_OFF_MAT, 32'h0);
        ctrl(4'h0, 2'h2, 4'h1);
        cli_connected <= 4'h2;
        sb(8'h0D);
        wt(0);
        chk("half one client", {28'h0, end_dest}, 32'h2);
        cli_connected <= 4'h3;
        sb(8'h0D);
        wt(0);
        chk("half last client", {28'h0, end_dest}, 32'h1);
        $display("test timeouts done");
    endtask : t_timeouts

    task automatic t_irq();
        apb(1'b1, SFP_OFF_MASK, 32'h0);
        apb(1'b1, SFP_OFF_IRQ, 32'h7);
        sb(8'h0D);
        wt(0);
        rd(SFP_OFF_IRQ, 32'h7, 32'h1);
        chk("irq raised", {31'h0, irq}, 32'h1);
        apb(1'b1, SFP_OFF_MASK, 32'h1);
        @(posedge pclk);
        chk("irq masked", {31'h0, irq}, 32'h0);
        apb(1'b1, SFP_OFF_MASK, 32'h0);
        apb(1'b1, SFP_OFF_IRQ, 32'h1);
        @(posedge pclk);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        apb(1'b0, 8'h30, 32'h0);
        chk("unmapped error", {31'h0, e}, 32'h1);
        apb(1'b0, SFP_OFF_FILL, 32'h0);
        chk("mapped no error", {31'h0, e}, 32'h0);
        $display("test irq done");
    endtask : t_irq

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite, req_sent, req_last, tx_go, reply_en} = 7'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        {req_client, cli_connected, app_seen, end_dest} = 16'h0;
        {tx_b, reply_gap, end_data} = {8'h00, 8'h03, 8'h00};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_defaults();
        t_apply();
        t_flush();
        t_timeouts();
        t_irq();
        test_done();
    end
endmodule : test_serial_to_net_packetizer
